// ---- hdl/bspc_pkg.sv ----
// constants, types and register map of the boot strap pin capture block
package bspc_pkg;

  // ************************************************************
  // register map, byte addresses on the configuration bus
  // ************************************************************
  localparam logic [31:0] BSPC_ROM_BASE       = 32'h0000_0000;
  localparam logic [31:0] BSPC_CAP_LOW_ADDR   = 32'h4000_0000;
  localparam logic [31:0] BSPC_CAP_HIGH_ADDR  = 32'h4000_0004;
  localparam logic [31:0] BSPC_CFG_REGION_END = 32'h4000_0083;

  // ************************************************************
  // widths and reset values
  // ************************************************************
  localparam int          BSPC_CAP_BITS     = 8;
  localparam int          BSPC_PIN_COUNT    = 16;
  localparam logic [7:0]  BSPC_CAP_RESET    = 8'h00;
  localparam logic [31:0] BSPC_RDATA_RESET  = 32'h0000_0000;
  localparam logic [23:0] BSPC_RSVD_READ    = 24'h00_0000;
  localparam logic        BSPC_EXT_RST_IDLE = 1'b1;
  localparam logic [15:0] BSPC_PINS_IDLE    = 16'h0000;

  // ************************************************************
  // field positions inside the capture words
  // ************************************************************
  localparam int BSPC_LOW_SLAVE_OUT = 7;
  localparam int BSPC_LOW_SLAVE_IN  = 6;
  localparam int BSPC_LOW_CLOCK     = 5;
  localparam int BSPC_HIGH_HOST_SEL = 5;
  localparam int BSPC_HIGH_HOST_D0  = 4;

  // host port configuration bit positions
  localparam int         BSPC_HPC_BYTE_ADDR = 2;
  localparam int         BSPC_HPC_FULL      = 1;
  localparam int         BSPC_HPC_NON_MUX   = 0;
  localparam logic [2:0] BSPC_HPC_RESET     = 3'h0;

  // ************************************************************
  // decoded boot mode codes
  // ************************************************************
  localparam logic [2:0] BSPC_BM_HOST       = 3'h0;
  localparam logic [2:0] BSPC_BM_FLASH      = 3'h1;
  localparam logic [2:0] BSPC_BM_SER_MASTER = 3'h2;
  localparam logic [2:0] BSPC_BM_SER_SLAVE  = 3'h3;
  localparam logic [2:0] BSPC_BM_TWI_MASTER = 3'h4;
  localparam logic [2:0] BSPC_BM_TWI_SLAVE  = 3'h5;
  localparam logic [2:0] BSPC_BM_INVALID    = 3'h7;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bspc_req_t;

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } bspc_cap_t;

  // capture sequencer, one-hot
  typedef enum logic [1:0] {
    BSPC_ST_RUN  = 2'b01,
    BSPC_ST_HELD = 2'b10
  } bspc_state_t;

endpackage

// ---- hdl/bspc_sync.sv ----
// two-stage synchroniser for asynchronous pin levels
module bspc_sync
  import bspc_pkg::*;
#(
  parameter int           WIDTH = 1,
  parameter logic [WIDTH-1:0] IDLE  = '0
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output      logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_sync_out;

  // ************************************************************
  // next values; stage1 feeds only the second stage
  // ************************************************************
  always_comb begin
    next_stage1   = async_in;
    next_sync_out = stage1;
  end

  // idle value keeps a reset from looking like a pin edge
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stage1   <= IDLE;
      sync_out <= IDLE;
    end else begin
      stage1   <= next_stage1;
      sync_out <= next_sync_out;
    end
  end

endmodule

// ---- hdl/bspc_top.sv ----
// boot strap pin capture: pin capture words, boot decode and register port
//
// Summary of operation
// R1: After reset, instruction fetch starts from the internal ROM at address zero.
// R2: The low capture word holds eight serial, two-wire and audio pin levels in bits 7..0.
// R3: The high capture word holds eight more pins, host select in bit 5, host data 0 in bit 4.
// R4: Each capture bit samples its pin when the external reset is released and then holds.
// R5: Only the external reset pin reloads the capture words, no internal reset does.
// R6: Debug and timer resets leave both capture words at their last captured values.
// R7: Bits 31..8 of each capture word are reserved; they read zero, software writes zeros.
// R8: The board straps host select and three serial pins to pick the boot mode.
// R9: With host select low, the three serial pins are copied to the host port config bits.
// R10: No requester accesses past the end of the configuration register region.
// R11: The configuration region is accessed with whole words only.
// R12: Writes to the capture words are ignored in every bit.
module bspc_top
  import bspc_pkg::*;
#(
  parameter int PIN_COUNT = BSPC_PIN_COUNT
) (
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  input  wire logic                 debug_reset_req,
  input  wire logic                 rti_reset_req,
  input  wire logic                 ext_reset_n,
  input  wire logic [PIN_COUNT-1:0] boot_pins,
  input  wire bspc_req_t            bus_req,
  output      logic [31:0]          bus_rdata,
  output      bspc_cap_t            capture,
  output      logic [2:0]           host_port_config_word,
  output      logic [2:0]           boot_mode,
  output      logic                 pins_captured,
  output      logic                 fetch_enable,
  output      logic [31:0]          fetch_addr
);

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic                 ext_reset_n_sync;
  logic [PIN_COUNT-1:0] pins_sync;

  // reset pin idles released so an internal reset fakes no edge
  bspc_sync #(
    .WIDTH (1),
    .IDLE  (BSPC_EXT_RST_IDLE)
  ) u_sync_reset (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in (ext_reset_n),
    .sync_out (ext_reset_n_sync)
  );

  // pins run through the same depth, so they line up with the edge
  bspc_sync #(
    .WIDTH (PIN_COUNT),
    .IDLE  (PIN_COUNT'(BSPC_PINS_IDLE))
  ) u_sync_pins (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in (boot_pins),
    .sync_out (pins_sync)
  );

  // ************************************************************
  // internal resets
  // ************************************************************
  logic internal_reset;

  // debug and timer requests restart fetch only
  assign internal_reset = rst | debug_reset_req | rti_reset_req;

  // ************************************************************
  // capture sequencer
  // ************************************************************
  bspc_state_t state;
  bspc_state_t next_state;
  bspc_cap_t   next_capture;
  logic        next_pins_captured;
  logic        release_edge;

  // release seen while held is the rising edge of the pin
  assign release_edge = (state == BSPC_ST_HELD) && ext_reset_n_sync;

  always_comb begin
    next_state         = state;
    next_capture       = capture;
    next_pins_captured = pins_captured;
    case (state)
      BSPC_ST_RUN: begin
        // R5: pin assertion arms recapture
        if (!ext_reset_n_sync) begin
          next_state         = BSPC_ST_HELD;
          next_capture.low   = BSPC_CAP_RESET;
          next_capture.high  = BSPC_CAP_RESET;
          next_pins_captured = 1'b0;
        end
      end
      BSPC_ST_HELD: begin
        if (release_edge) begin
          next_state         = BSPC_ST_RUN;
          // R2: low word pin levels
          next_capture.low   = pins_sync[BSPC_CAP_BITS-1:0];
          // R3: high word pin levels
          next_capture.high  = pins_sync[PIN_COUNT-1:BSPC_CAP_BITS];
          // R4: sample at release
          next_pins_captured = 1'b1;
        end
      end
      default: begin
        next_state = BSPC_ST_RUN;
      end
    endcase
  end

  // R6: capture words take no internal reset; only the sequencer does
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= BSPC_ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  // R4: hold between external resets
  always_ff @(posedge sys_clk) begin
    capture       <= next_capture;
    pins_captured <= next_pins_captured;
  end

  // ************************************************************
  // boot decode from the captured straps
  // ************************************************************
  logic       cap_host_sel;
  logic [2:0] cap_serial;
  logic [2:0] next_host_port_config_word;
  logic [2:0] next_boot_mode;

  assign cap_host_sel = capture.high[BSPC_HIGH_HOST_SEL];
  assign cap_serial   = {capture.low[BSPC_LOW_SLAVE_OUT],
                         capture.low[BSPC_LOW_SLAVE_IN],
                         capture.low[BSPC_LOW_CLOCK]};

  always_comb begin
    next_host_port_config_word = BSPC_HPC_RESET;
    next_boot_mode             = BSPC_BM_INVALID;
    if (!cap_host_sel) begin
      // R9: straps into host port config
      next_host_port_config_word[BSPC_HPC_BYTE_ADDR] = cap_serial[2];
      next_host_port_config_word[BSPC_HPC_FULL]      = cap_serial[1];
      next_host_port_config_word[BSPC_HPC_NON_MUX]   = cap_serial[0];
      next_boot_mode = BSPC_BM_HOST;
    end else begin
      // R8: board strap combinations, others flagged invalid
      case (cap_serial)
        3'h2:    next_boot_mode = BSPC_BM_FLASH;
        3'h1:    next_boot_mode = BSPC_BM_SER_MASTER;
        3'h3:    next_boot_mode = BSPC_BM_SER_SLAVE;
        3'h5:    next_boot_mode = BSPC_BM_TWI_MASTER;
        3'h7:    next_boot_mode = BSPC_BM_TWI_SLAVE;
        default: next_boot_mode = BSPC_BM_INVALID;
      endcase
    end
  end

  // decode lags the capture by one cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      host_port_config_word <= BSPC_HPC_RESET;
      boot_mode             <= BSPC_BM_INVALID;
    end else begin
      host_port_config_word <= next_host_port_config_word;
      boot_mode             <= next_boot_mode;
    end
  end

  // ************************************************************
  // instruction fetch start
  // ************************************************************
  logic        next_fetch_enable;
  logic [31:0] next_fetch_addr;

  always_comb begin
    // R1: fetch from ROM base
    next_fetch_addr   = BSPC_ROM_BASE;
    next_fetch_enable = 1'b0;
    // fetch waits while the external pin still holds the part
    if (!internal_reset && (next_state == BSPC_ST_RUN)) begin
      next_fetch_enable = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fetch_enable <= 1'b0;
      fetch_addr   <= BSPC_ROM_BASE;
    end else begin
      fetch_enable <= next_fetch_enable;
      fetch_addr   <= next_fetch_addr;
    end
  end

  // ************************************************************
  // register port
  // ************************************************************
  logic [31:0] next_bus_rdata;

  // R11: whole-word decode, address must match exactly
  always_comb begin
    next_bus_rdata = BSPC_RDATA_RESET;
    if (bus_req.rd) begin
      case (bus_req.addr)
        // R7: reserved bits read zero
        BSPC_CAP_LOW_ADDR:  next_bus_rdata = {BSPC_RSVD_READ, capture.low};
        BSPC_CAP_HIGH_ADDR: next_bus_rdata = {BSPC_RSVD_READ, capture.high};
        default:            next_bus_rdata = BSPC_RDATA_RESET;
      endcase
    end
    // R12: writes have no target here, bus_req.wr is dropped
  end

  // read data stands for one cycle only
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bus_rdata <= BSPC_RDATA_RESET;
    end else begin
      bus_rdata <= next_bus_rdata;
    end
  end

endmodule

// ---- verif/bspc_assertions.sv ----
// checker on the ports of the boot strap pin capture top
module bspc_assertions
  import bspc_pkg::*;
#(
  parameter int PIN_COUNT = BSPC_PIN_COUNT
) (
  input wire logic                 sys_clk,
  input wire logic                 rst,
  input wire logic                 debug_reset_req,
  input wire logic                 rti_reset_req,
  input wire logic                 ext_reset_n,
  input wire logic [PIN_COUNT-1:0] boot_pins,
  input wire bspc_req_t            bus_req,
  input wire logic [31:0]          bus_rdata,
  input wire bspc_cap_t            capture,
  input wire logic [2:0]           host_port_config_word,
  input wire logic [2:0]           boot_mode,
  input wire logic                 pins_captured,
  input wire logic                 fetch_enable,
  input wire logic [31:0]          fetch_addr
);
  // ****************
  // properties
  // ****************
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [31:0] a;
  // short alias for the request address
  assign a = bus_req.addr;

  a_fetch_base: assert property (fetch_addr == BSPC_ROM_BASE)
    else $error("fetch address left the rom base");
  a_fetch_gated: assert property (debug_reset_req || rti_reset_req |=> !fetch_enable)
    else $error("fetch kept running under an internal reset");
  a_read_low: assert property (bus_req.rd && a == BSPC_CAP_LOW_ADDR
    |=> bus_rdata == {24'h00_0000, $past(capture.low)}) else $error("low word read wrong");
  a_read_high: assert property (bus_req.rd && a == BSPC_CAP_HIGH_ADDR
    |=> bus_rdata == {24'h00_0000, $past(capture.high)}) else $error("high word read wrong");
  a_read_unmapped: assert property (bus_req.rd && a != BSPC_CAP_LOW_ADDR
    && a != BSPC_CAP_HIGH_ADDR |=> bus_rdata == 32'h0) else $error("unmapped read not zero");
  a_capture_load: assert property ($rose(pins_captured)
    |-> capture == $past(boot_pins, 3)) else $error("capture differs from pins at release");
  a_capture_hold: assert property (ext_reset_n [*5] |-> $stable(capture))
    else $error("capture moved without an external reset");
  a_host_cfg: assert property ($rose(pins_captured) |=> host_port_config_word ==
    (capture.high[5] ? 3'h0 : capture.low[7:5])) else $error("host config copy wrong");
  a_ext_clear: assert property (!ext_reset_n [*3] |=> !pins_captured)
    else $error("capture flag not cleared by the held pin");

  c_capture: cover property ($rose(pins_captured));
  c_read: cover property (bus_req.rd && a == BSPC_CAP_HIGH_ADDR);
  c_internal: cover property (rti_reset_req);
endmodule

bind bspc_top bspc_assertions #(.PIN_COUNT(PIN_COUNT)) u_chk (.sys_clk, .rst,
  .debug_reset_req, .rti_reset_req, .ext_reset_n, .boot_pins, .bus_req, .bus_rdata,
  .capture, .host_port_config_word, .boot_mode, .pins_captured, .fetch_enable, .fetch_addr);

// ---- verif/bspc_strap_model.sv ----
// board strapping model: drives the boot pins and the external reset pin
module bspc_strap_model (
  input  wire logic        sys_clk,
  output      logic        ext_reset_n,
  output      logic [15:0] boot_pins
);
  timeunit 1ns;
  timeprecision 1ps;

  // power up with the reset pin held
  initial begin
    ext_reset_n = 1'b0;
    boot_pins = 16'h0000;
  end

  // straps held steady
  // pins stand from assertion until three clocks after release
  task automatic strap(input logic [15:0] p);
    @(posedge sys_clk);
    ext_reset_n <= 1'b0;
    boot_pins <= p;
    repeat (4) @(posedge sys_clk);
    ext_reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    boot_pins <= ~p; // hold time over, so the old level must not linger
  endtask
endmodule

// ---- verif/bspc_top_tb.sv ----
// self-checking bench for the boot strap pin capture block
module bspc_top_tb;
  import bspc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [15:0] pins;
    logic [2:0]  mode;
    logic [2:0]  hpc;
  } bspc_row_t;
  // one strap set per boot mode, with the expected decode
  localparam bspc_row_t ROWS [7] = '{
    '{16'h5ca3, BSPC_BM_HOST, 3'h5}, '{16'h2040, BSPC_BM_FLASH, 3'h0},
    '{16'hff3f, BSPC_BM_SER_MASTER, 3'h0}, '{16'ha175, BSPC_BM_SER_SLAVE, 3'h0},
    '{16'h3ebc, BSPC_BM_TWI_MASTER, 3'h0}, '{16'h27e0, BSPC_BM_TWI_SLAVE, 3'h0},
    '{16'h2000, BSPC_BM_INVALID, 3'h0}};

  logic        sys_clk = 1'b0;
  logic        rst, debug_reset_req, rti_reset_req, ext_reset_n;
  logic        pins_captured, fetch_enable;
  logic [15:0] boot_pins;
  bspc_req_t   bus_req;
  bspc_cap_t   capture;
  logic [31:0] bus_rdata, fetch_addr, d;
  logic [2:0]  host_port_config_word, boot_mode;
  int          err_count = 0;
  int          check_count = 0;

  // ****************
  // clock, parts
  // ****************
  always #12.5 sys_clk = ~sys_clk;

  bspc_strap_model u_model (.sys_clk, .ext_reset_n, .boot_pins);
  bspc_top dut (.sys_clk, .rst, .debug_reset_req, .rti_reset_req, .ext_reset_n, .boot_pins,
    .bus_req, .bus_rdata, .capture, .host_port_config_word, .boot_mode, .pins_captured,
    .fetch_enable, .fetch_addr);

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one bus cycle; a read leaves its data in d
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: wd, wr: w, rd: !w};
    @(posedge sys_clk);
    bus_req <= '0;
    #1 d = bus_rdata;
  endtask

  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ****************
  // tests
  // ****************
  initial begin
    rst = 1'b1;
    debug_reset_req = 1'b0;
    rti_reset_req = 1'b0;
    bus_req = '0;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    // pins change after each call, so later reads also prove the hold
    foreach (ROWS[i]) begin
      u_model.strap(ROWS[i].pins);
      bus(1'b0, BSPC_CAP_LOW_ADDR, 32'h0);
      chk(d, {24'h00_0000, ROWS[i].pins[7:0]});
      bus(1'b0, BSPC_CAP_HIGH_ADDR, 32'h0);
      chk(d, {24'h00_0000, ROWS[i].pins[15:8]});
      chk(32'(boot_mode), 32'(ROWS[i].mode));
      chk(32'(host_port_config_word), 32'(ROWS[i].hpc));
      chk(32'(pins_captured), 32'h1);
      $display("strap row %0d done", i);
    end
    // writes bounce off, two writes with an idle cycle between them
    bus(1'b1, BSPC_CAP_LOW_ADDR, 32'hffff_ffff);
    bus(1'b1, BSPC_CAP_HIGH_ADDR, 32'h0000_00ff);
    chk(32'(capture), 32'h0000_2000);
    // unmapped probes stay inside the configuration region
    bus(1'b0, 32'h4000_0008, 32'h0);
    chk(d, 32'h0);
    bus(1'b0, 32'h4000_0002, 32'h0);
    chk(d, 32'h0);
    $display("bus test done");
    // debug, timer and system resets keep the captured words
    @(posedge sys_clk);
    debug_reset_req <= 1'b1;
    @(posedge sys_clk);
    #1 chk(32'(fetch_enable), 32'h0);
    @(posedge sys_clk);
    debug_reset_req <= 1'b0;
    rti_reset_req <= 1'b1;
    @(posedge sys_clk);
    #1 chk(32'(fetch_enable), 32'h0);
    @(posedge sys_clk);
    rti_reset_req <= 1'b0;
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1 chk(32'(capture), 32'h0000_2000);
    chk(32'(fetch_enable), 32'h1);
    chk(fetch_addr, BSPC_ROM_BASE);
    $display("internal reset test done");
    wrap_up();
  end

  // watchdog, far beyond the hundred or so cycles the tests need
  initial begin
    repeat (4000) @(posedge sys_clk);
    err_count++;
    wrap_up();
  end
endmodule
